// file: common/rlt_consts.svh
`ifndef RLT_CONSTS_SVH
`define RLT_CONSTS_SVH
`define RLT_OP_TBL 8'hA5
`define RLT_OP_RD3 8'h03
`define RLT_OP_RD4 8'h13
`define RLT_OP_FAST3 8'h0B
`define RLT_OP_FAST4 8'h0C
`define RLT_OP_DOUT3 8'h3B
`define RLT_OP_DOUT4 8'h3C
`define RLT_OP_QOUT3 8'h6B
`define RLT_OP_QOUT4 8'h6C
`define RLT_OP_DIO3 8'hBB
`define RLT_OP_DIO4 8'hBC
`define RLT_OP_QIO3 8'hEB
`define RLT_OP_QIO4 8'hEC
`define RLT_OP_DFAST3 8'h0D
`define RLT_OP_DFAST4 8'h0E
`define RLT_OP_DDIO3 8'hBD
`define RLT_OP_DDIO4 8'hBE
`define RLT_OP_DQIO3 8'hED
`define RLT_OP_DQIO4 8'hEE
`define RLT_SDR_ID 8'h90
`define RLT_SDR_LEN 8'h56
`define RLT_SDR_ROWS 8'h06
`define RLT_SDR_RLEN 8'h0E
`define RLT_SDR_ROW0 8'h12
`define RLT_DDR_ID 8'h9A
`define RLT_DDR_LEN 8'h2A
`define RLT_DDR_ROWS 8'h05
`define RLT_DDR_RLEN 8'h08
`define RLT_DDR_ROW0 8'h0C
`define RLT_DDR_BASE 8'h58
`define RLT_TBL_END 8'h84
`define RLT_HDR_F 8'h46
`define RLT_HDR_C 8'h43
`define RLT_UNSUP 8'hFF
`define RLT_F50 8'h32
`define RLT_F66 8'h42
`define RLT_F80 8'h50
`define RLT_F90 8'h5A
`define RLT_F104 8'h68
`define RLT_F133 8'h85
`define RLT_ROW_HIGH 3'h4
`define RLT_OP_LAST 5'h07
`define RLT_ADDR_LAST 5'h0F
`define RLT_HDR_CNT 5'h10
`define RLT_HDR_BITS 12'h010
`define RLT_SCK_HALF 3
`define RLT_FIFO_DEPTH 16
`endif

// file: common/rlt_if.sv
`timescale 1ns/1ps
interface rlt_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso;
   modport dev (input sclk, input cs_n, input mosi, output miso);
   modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

// file: common/rlt_pkg.sv
`include "rlt_consts.svh"
package rlt_pkg;
   typedef enum logic [3:0] {
      RLT_RD = 4'h0, RLT_FAST = 4'h1, RLT_DOUT = 4'h2, RLT_QOUT = 4'h3,
      RLT_DIO = 4'h4, RLT_QIO = 4'h5, RLT_DFAST = 4'h6, RLT_DDIO = 4'h7,
      RLT_DQIO = 4'h8, RLT_NONE = 4'hF
   } rlt_cmd_e;

   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] dummy;
   } rlt_cyc_s;

   typedef enum logic [2:0] {
      HS_IDLE = 3'b001, HS_RUN = 3'b010, HS_END = 3'b100
   } rlt_hstate_e;

   function automatic logic [7:0] op_of(input logic [3:0] c,
                                        input logic a4);
      case ({c, a4})
         5'h00: op_of = `RLT_OP_RD3;
         5'h01: op_of = `RLT_OP_RD4;
         5'h02: op_of = `RLT_OP_FAST3;
         5'h03: op_of = `RLT_OP_FAST4;
         5'h04: op_of = `RLT_OP_DOUT3;
         5'h05: op_of = `RLT_OP_DOUT4;
         5'h06: op_of = `RLT_OP_QOUT3;
         5'h07: op_of = `RLT_OP_QOUT4;
         5'h08: op_of = `RLT_OP_DIO3;
         5'h09: op_of = `RLT_OP_DIO4;
         5'h0A: op_of = `RLT_OP_QIO3;
         5'h0B: op_of = `RLT_OP_QIO4;
         5'h0C: op_of = `RLT_OP_DFAST3;
         5'h0D: op_of = `RLT_OP_DFAST4;
         5'h0E: op_of = `RLT_OP_DDIO3;
         5'h0F: op_of = `RLT_OP_DDIO4;
         5'h10: op_of = `RLT_OP_DQIO3;
         5'h11: op_of = `RLT_OP_DQIO4;
         default: op_of = `RLT_OP_TBL;
      endcase
   endfunction

   function automatic rlt_cmd_e op_cmd(input logic [7:0] op);
      op_cmd = RLT_NONE;
      for (int i = 0; i < 18; i++)
      begin
         if (op_of(4'(i / 2), i[0]) == op)
            op_cmd = rlt_cmd_e'(4'(i / 2));
      end
   endfunction

   // rows in table order: 11b, 00b, 01b, 10b, 10b above 104 MHz
   function automatic logic [2:0] row_of(input logic [1:0] code,
                                         input logic high);
      case (code)
         2'b11: row_of = 3'h0;
         2'b00: row_of = 3'h1;
         2'b01: row_of = 3'h2;
         default: row_of = high ? `RLT_ROW_HIGH : 3'h3;
      endcase
   endfunction

   function automatic logic [7:0] pick(input logic [2:0] row,
                                       input logic [31:0] d);
      pick = d[8 * row[1:0] +: 8];
   endfunction

   function automatic rlt_cyc_s cyc(input logic [2:0] row,
                                    input rlt_cmd_e c);
      logic hi;
      hi = (row == `RLT_ROW_HIGH);
      cyc = {`RLT_UNSUP, `RLT_UNSUP};
      case (c)
         RLT_RD: if (row == 3'h0) cyc = '0;
         RLT_FAST: cyc = (row == 3'h0) ? '0 : {8'h00, 8'h08};
         RLT_DOUT, RLT_QOUT:
            if (!hi) cyc = (row == 3'h0) ? '0 : {8'h00, 8'h08};
         RLT_DIO: if (!hi) cyc = {8'h04, pick(row, 32'h02010000)};
         RLT_QIO: if (!hi) cyc = {8'h02, pick(row, 32'h05040401)};
         RLT_DFAST: if (!hi) cyc = {8'h04, pick(row, 32'h05040201)};
         RLT_DDIO: if (!hi) cyc = {8'h02, pick(row, 32'h06050402)};
         RLT_DQIO: if (!hi) cyc = {8'h01, pick(row, 32'h08070603)};
         default: cyc = {`RLT_UNSUP, `RLT_UNSUP};
      endcase
   endfunction
endpackage

// file: testbench/read_latency_table_tb.sv
`timescale 1ns/1ps
module read_latency_table_tb;
   logic clk, rst;
   logic [1:0] lat_code = 2'h0;
   logic high_band = 1'b0, req_valid = 1'b0, rx_ready = 1'b0;
   logic [7:0] req_op = 8'h00, req_addr = 8'h00, req_len = 8'h00;
   logic cmd_valid, cmd_addr4, cmd_ok, req_ready, req_reject;
   logic rx_valid, busy;
   rlt_pkg::rlt_cmd_e cmd_kind;
   logic [7:0] cmd_mode, cmd_dummy, rx_data, param_next;
   int n_fail = 0;
   int n_tests = 0;
   logic [7:0] sdr_b [18] = '{8'h90, 8'h56, 8'h06, 8'h0E, 8'h46, 8'h43,
      8'h03, 8'h13, 8'h0B, 8'h0C, 8'h3B, 8'h3C, 8'h6B, 8'h6C, 8'hBB,
      8'hBC, 8'hEB, 8'hEC};
   logic [7:0] ddr_b [13] = '{8'h9A, 8'h2A, 8'h05, 8'h08, 8'h46, 8'h43,
      8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE, 8'h32};

   rlt_if link_if();
   rlt_dev rlt_dev_inst (.rst(rst), .clk(clk), .link(link_if),
      .lat_code(lat_code), .high_band(high_band), .cmd_valid(cmd_valid),
      .cmd_kind(cmd_kind), .cmd_addr4(cmd_addr4), .cmd_ok(cmd_ok),
      .cmd_mode(cmd_mode), .cmd_dummy(cmd_dummy));
   rlt_host #(.SCK_HALF(3), .DEPTH(16)) rlt_host_inst (.rst(rst),
      .clk(clk), .link(link_if), .lat_code(lat_code),
      .high_band(high_band), .req_valid(req_valid), .req_ready(req_ready),
      .req_op(req_op), .req_addr(req_addr), .req_len(req_len),
      .req_reject(req_reject), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rx_data(rx_data), .param_next(param_next), .busy(busy));
   rlt_link_checker rlt_link_checker_inst (.clk(clk), .rst(rst),
      .sclk(link_if.sclk), .cs_n(link_if.cs_n), .mosi(link_if.mosi),
      .miso(link_if.miso));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic close_out;
      $display("tests %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, exp, input string m);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("FAIL %0t %s got %h want %h", $time, m, got, exp);
      end
   endtask

   task automatic step;
      @(posedge clk);
      #1;
   endtask

   // held until an edge that sees the host idle
   task automatic req(input logic [7:0] op, a, n);
      int k;
      k = 0;
      // always one edge first, so req_valid never drops and rises at once
      do
      begin
         step();
         k++;
      end while (req_ready !== 1'b1 && k < 3000);
      if (req_ready !== 1'b1)
         chk(8'h00, 8'h01, "request timeout");
      req_op = op;
      req_addr = a;
      req_len = n;
      req_valid = 1'b1;
      step();
      req_valid = 1'b0;
   endtask

   task automatic pop(input logic [7:0] e);
      int k;
      k = 0;
      do
      begin
         step();
         k++;
      end while (rx_valid !== 1'b1 && k < 3000);
      if (rx_valid !== 1'b1)
         chk(8'h00, 8'h01, "reply timeout");
      chk(rx_data, e, "reply byte");
      rx_ready = 1'b1;
      step();
      rx_ready = 1'b0;
   endtask

   // md of FFh means the host must refuse the command
   task automatic cmd(input logic [2:0] ch, input logic [7:0] op, md, dm,
      input logic [4:0] ka);
      int k;
      k = 0;
      {lat_code, high_band} = ch;
      req(op, 8'h00, 8'h00);
      while (cmd_valid !== 1'b1 && req_reject !== 1'b1 && k < 400)
      begin
         step();
         k++;
      end
      if (cmd_valid !== 1'b1 && req_reject !== 1'b1)
         chk(8'h00, 8'h01, "no answer");
      chk({7'h00, req_reject}, {7'h00, md == 8'hFF}, "refusal");
      if (md != 8'hFF)
      begin
         chk(cmd_mode, md, "mode count");
         chk(cmd_dummy, dm, "dummy count");
         chk({7'h00, cmd_ok}, 8'h01, "supported");
         chk({3'h0, cmd_kind, cmd_addr4}, {3'h0, ka}, "kind");
      end
   endtask

   initial
   begin
      rst = 1'b1;
      repeat (10) @(posedge clk);
      #1;
      rst = 1'b0;
      cmd(3'h6, 8'h03, 8'h00, 8'h00, 5'h00);
      cmd(3'h6, 8'hEB, 8'h02, 8'h01, 5'h0A);
      cmd(3'h6, 8'hBB, 8'h04, 8'h00, 5'h08);
      cmd(3'h0, 8'h03, 8'hFF, 8'hFF, 5'h00);
      cmd(3'h0, 8'h3B, 8'h00, 8'h08, 5'h04);
      cmd(3'h2, 8'h0B, 8'h00, 8'h08, 5'h02);
      cmd(3'h2, 8'h6C, 8'h00, 8'h08, 5'h07);
      cmd(3'h2, 8'hBB, 8'h04, 8'h01, 5'h08);
      cmd(3'h2, 8'hEC, 8'h02, 8'h04, 5'h0B);
      cmd(3'h4, 8'h3C, 8'h00, 8'h08, 5'h05);
      cmd(3'h4, 8'hBC, 8'h04, 8'h02, 5'h09);
      cmd(3'h4, 8'hEB, 8'h02, 8'h05, 5'h0A);
      cmd(3'h5, 8'h0C, 8'h00, 8'h08, 5'h03);
      cmd(3'h5, 8'h6B, 8'hFF, 8'hFF, 5'h00);
      cmd(3'h5, 8'hEB, 8'hFF, 8'hFF, 5'h00);
      cmd(3'h2, 8'h13, 8'hFF, 8'hFF, 5'h00);
      cmd(3'h4, 8'h03, 8'hFF, 8'hFF, 5'h00);
      cmd(3'h6, 8'h0D, 8'h04, 8'h01, 5'h0C);
      cmd(3'h2, 8'h0E, 8'h04, 8'h04, 5'h0D);
      cmd(3'h6, 8'hBD, 8'h02, 8'h02, 5'h0E);
      cmd(3'h2, 8'hBE, 8'h02, 8'h05, 5'h0F);
      cmd(3'h6, 8'hED, 8'h01, 8'h03, 5'h10);
      cmd(3'h2, 8'hEE, 8'h01, 8'h07, 5'h11);
      {lat_code, high_band} = 3'h6;
      req(8'h03, 8'h00, 8'h00);
      // code moves after the host's check: only the device sees 01b
      lat_code = 2'h1;
      while (cmd_valid !== 1'b1)
         step();
      chk({7'h00, cmd_ok}, 8'h00, "device refusal");
      chk(cmd_mode, 8'hFF, "unsupported mode");
      chk(cmd_dummy, 8'hFF, "unsupported dummy");
      chk({3'h0, cmd_kind, cmd_addr4}, 8'h00, "kind");
      $display("command tests done");
      req(8'hA5, 8'h00, 8'h12);
      // long enough for sixteen bytes to land with nothing popped
      repeat (1500) @(posedge clk);
      #1;
      chk({7'h00, busy}, 8'h01, "stalled on full buffer");
      for (int i = 0; i < 18; i++)
         pop(sdr_b[i]);
      chk(param_next, 8'h58, "next parameter");
      req(8'hA5, 8'h58, 8'h0D);
      for (int i = 0; i < 13; i++)
         pop(ddr_b[i]);
      chk(param_next, 8'h84, "next parameter");
      $display("table tests done");
      close_out();
   end

   initial
   begin
      #1000000;
      n_fail++;
      close_out();
   end
endmodule

// file: testbench/rlt_link_checker.sv
`timescale 1ns/1ps
module rlt_link_checker
(
   input wire logic clk, // system clock
   input wire logic rst, // async reset, active high
   input wire logic sclk, // link clock
   input wire logic cs_n, // frame select
   input wire logic mosi, // host data
   input wire logic miso // device data
);
   logic sclk_reg;
   logic [9:0] rise_reg;

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   always_ff @(posedge clk or posedge rst)
      if (rst)
         sclk_reg <= 1'b0;
      else
         sclk_reg <= sclk;

   // counts link rises per frame; cleared between frames
   always_ff @(posedge clk or posedge rst)
      if (rst)
         rise_reg <= 10'h000;
      else if (cs_n)
         rise_reg <= 10'h000;
      else if (sclk && !sclk_reg)
         rise_reg <= rise_reg + 10'h001;

   sequence frame_open;
      !sclk [*3] ##1 sclk;
   endsequence

   a_sclk_idle: assert property (cs_n |-> !sclk)
      else $error("link clock active outside frame");
   a_miso_idle: assert property (cs_n |-> !miso)
      else $error("device data not low outside frame");
   a_frame_start: assert property ($fell(cs_n) |-> frame_open)
      else $error("first link rise not three cycles after select");
   a_high_time: assert property ($rose(sclk) |-> sclk [*3])
      else $error("link clock high phase too short");
   a_mosi_hold: assert property (sclk |-> $stable(mosi))
      else $error("host data moved while link clock high");
   a_miso_edge: assert property (!cs_n && $changed(miso) |-> $rose(sclk))
      else $error("device data moved away from a rise");
   a_frame_end: assert property ($rose(cs_n) |-> $fell(sclk))
      else $error("frame closed without link clock falling");
   a_bit_count: assert property ($rose(cs_n) |->
      rise_reg[2:0] == 3'h0 && rise_reg >= 10'h010)
      else $error("frame not a whole number of bytes");
endmodule

// file: verilog/rlt_dev.sv
`timescale 1ns/1ps
`include "rlt_consts.svh"

// Overview of operation
// R01: code 01b: fast/out reads zero mode, eight dummy
// R02: code 01b: dual I/O 4+1, quad I/O 2+4
// R03: code 10b: eight dummy; dual 4+2, quad 2+5
// R04: 133 MHz band: only fast read supported
// R05: plain read unsupported at 80/90/104/133, FFh
// R06: DDR fast read opcodes 0Dh / 0Eh
// R07: DDR dual I/O read opcodes BDh / BEh
// R08: DDR quad I/O read opcodes EDh / EEh
// R09: DDR parameter header 9Ah,2Ah,05h,08h,F,C
// R10: reader skips by length byte plus two
// R11: row: frequency, code, mode/dummy per command
// R12: code 11b: no dummy; dual 4+0, quad 2+1
// R13: code 00b: read unsupported, others as listed
// R14: host picks fitting code, applies its counts; host takes lat_code as given and adds no mode/dummy cycles
module rlt_dev
(
   input wire logic rst, // async reset, active high
   input wire logic clk, // system clock
   rlt_if.dev link, // serial link, device end
   input wire logic [1:0] lat_code, // latency code in use
   input wire logic high_band, // serial clock above 104 MHz
   output logic cmd_valid, // pulse: read command decoded
   output rlt_pkg::rlt_cmd_e cmd_kind, // decoded read kind
   output logic cmd_addr4, // 4-byte address form
   output logic cmd_ok, // command supported now
   output logic [7:0] cmd_mode, // mode cycles to apply
   output logic [7:0] cmd_dummy // dummy cycles to apply
);

   function automatic logic [7:0] freq_of(input int r,
                                          input logic ddr);
      if (ddr)
         freq_of = (r == 0) ? `RLT_F50 : `RLT_F66;
      else
      begin
         case (r)
            0: freq_of = `RLT_F50;
            1: freq_of = `RLT_F80;
            2: freq_of = `RLT_F90;
            3: freq_of = `RLT_F104;
            default: freq_of = `RLT_F133;
         endcase
      end
   endfunction

   // parameter bytes: 90h list at 00h, 9Ah list right after it
   function automatic logic [7:0] tbl_byte(input logic [7:0] a);
      int o;
      int k;
      int r;
      int col;
      int rl;
      logic ddr;
      logic [3:0] base;
      rlt_pkg::rlt_cyc_s cy;
      ddr = (a >= `RLT_DDR_BASE);
      base = ddr ? 4'h6 : 4'h0;
      o = ddr ? int'(a - `RLT_DDR_BASE) : int'(a);
      rl = ddr ? int'(`RLT_DDR_RLEN) : int'(`RLT_SDR_RLEN);
      k = 0;
      r = 0;
      col = 0;
      cy = '0;
      tbl_byte = `RLT_UNSUP;
      if (a >= `RLT_TBL_END)
         tbl_byte = `RLT_UNSUP;
      else if (o == 0)
         tbl_byte = ddr ? `RLT_DDR_ID : `RLT_SDR_ID; // R09
      else if (o == 1)
         tbl_byte = ddr ? `RLT_DDR_LEN : `RLT_SDR_LEN; // R09
      else if (o == 2)
         tbl_byte = ddr ? `RLT_DDR_ROWS : `RLT_SDR_ROWS; // R09
      else if (o == 3)
         tbl_byte = ddr ? `RLT_DDR_RLEN : `RLT_SDR_RLEN; // R09
      else if (o == 4)
         tbl_byte = `RLT_HDR_F; // R09
      else if (o == 5)
         tbl_byte = `RLT_HDR_C; // R09
      else if (o < int'(ddr ? `RLT_DDR_ROW0 : `RLT_SDR_ROW0))
      begin
         k = o - 6;
         tbl_byte = rlt_pkg::op_of(4'(k / 2) + base, k[0]); // R06 R07 R08
      end
      else
      begin
         k = o - int'(ddr ? `RLT_DDR_ROW0 : `RLT_SDR_ROW0);
         r = k / rl;
         col = k % rl;
         // header row excluded, so r counts data rows from zero
         if (col == 0)
            tbl_byte = freq_of(r, ddr); // R11
         else if (col == 1)
            tbl_byte = (r == 0) ? 8'h03 : 8'((r == 4) ? 2 : r - 1); // R11
         else
         begin
            cy = rlt_pkg::cyc(3'(r), rlt_pkg::rlt_cmd_e'(4'((col - 2) / 2)
                              + base));
            tbl_byte = col[0] ? cy.dummy : cy.mode; // R11
         end
      end
   endfunction

   // link side: frame state is cleared by cs_n, so no edge is
   // needed between frames
   logic frame_rst;
   logic [4:0] bit_cnt_reg;
   logic [7:0] in_sh_reg;
   logic [7:0] op_reg;
   logic [7:0] ptr_reg;
   logic [7:0] out_sh_reg;
   logic [2:0] out_bit_reg;
   logic [7:0] in_byte;

   assign frame_rst = rst | link.cs_n;
   assign in_byte = {in_sh_reg[6:0], link.mosi};
   assign link.miso = out_sh_reg[7];

   always_ff @(posedge link.sclk or posedge frame_rst)
   begin
      if (frame_rst)
         bit_cnt_reg <= '0;
      else if (bit_cnt_reg != `RLT_HDR_CNT)
         bit_cnt_reg <= bit_cnt_reg + 5'h01;
   end

   always_ff @(posedge link.sclk or posedge frame_rst)
   begin
      if (frame_rst)
         in_sh_reg <= '0;
      else if (bit_cnt_reg != `RLT_HDR_CNT)
         in_sh_reg <= in_byte;
   end

   always_ff @(posedge link.sclk or posedge frame_rst)
   begin
      if (frame_rst)
         op_reg <= '0;
      else if (bit_cnt_reg == `RLT_OP_LAST)
         op_reg <= in_byte;
   end

   // reply bytes stream from the addressed byte onward
   always_ff @(posedge link.sclk or posedge frame_rst)
   begin
      if (frame_rst)
      begin
         out_sh_reg <= '0;
         ptr_reg <= '0;
         out_bit_reg <= '0;
      end
      else if (bit_cnt_reg == `RLT_ADDR_LAST)
      begin
         if (op_reg == `RLT_OP_TBL)
         begin
            out_sh_reg <= tbl_byte(in_byte);
            ptr_reg <= in_byte + 8'h01;
         end
      end
      else if (bit_cnt_reg == `RLT_HDR_CNT)
      begin
         out_bit_reg <= out_bit_reg + 3'h1;
         if (out_bit_reg == 3'h7 && op_reg == `RLT_OP_TBL)
         begin
            out_sh_reg <= tbl_byte(ptr_reg);
            ptr_reg <= ptr_reg + 8'h01;
         end
         else
            out_sh_reg <= {out_sh_reg[6:0], 1'b0};
      end
   end

   // code crossing: only advances on sclk edges, so a new code
   // takes effect two edges into the next frame
   logic [1:0] code_s1_reg;
   logic [1:0] code_s2_reg;
   logic high_s1_reg;
   logic high_s2_reg;

   always_ff @(posedge link.sclk or posedge rst)
   begin
      if (rst)
      begin
         code_s1_reg <= '0;
         code_s2_reg <= '0;
         high_s1_reg <= 1'b0;
         high_s2_reg <= 1'b0;
      end
      else
      begin
         code_s1_reg <= lat_code;
         code_s2_reg <= code_s1_reg;
         high_s1_reg <= high_band;
         high_s2_reg <= high_s1_reg;
      end
   end

   // event held stable until the next toggle, which is at least
   // one whole frame later, so the clk side may sample it freely
   rlt_pkg::rlt_cmd_e dec_cmd;
   logic evt_tog_reg;
   logic evt_a4_reg;
   rlt_pkg::rlt_cmd_e evt_cmd_reg;
   rlt_pkg::rlt_cyc_s evt_cyc_reg;

   assign dec_cmd = rlt_pkg::op_cmd(in_byte); // R06 R07 R08

   always_ff @(posedge link.sclk or posedge rst)
   begin
      if (rst)
      begin
         evt_tog_reg <= 1'b0;
         evt_a4_reg <= 1'b0;
         evt_cmd_reg <= rlt_pkg::RLT_NONE;
         evt_cyc_reg <= '0;
      end
      else if (bit_cnt_reg == `RLT_OP_LAST &&
               dec_cmd != rlt_pkg::RLT_NONE)
      begin
         evt_tog_reg <= ~evt_tog_reg;
         evt_cmd_reg <= dec_cmd;
         evt_a4_reg <= (rlt_pkg::op_of(dec_cmd, 1'b1) == in_byte);
         // R01 R02 R03 R04 R05 R12 R13
         evt_cyc_reg <= rlt_pkg::cyc(rlt_pkg::row_of(code_s2_reg,
                                     high_s2_reg), dec_cmd);
      end
   end

   // system clock side
   logic tog_s1_reg;
   logic tog_s2_reg;
   logic tog_s3_reg;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tog_s1_reg <= 1'b0;
         tog_s2_reg <= 1'b0;
         tog_s3_reg <= 1'b0;
      end
      else
      begin
         tog_s1_reg <= evt_tog_reg;
         tog_s2_reg <= tog_s1_reg;
         tog_s3_reg <= tog_s2_reg;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cmd_valid <= 1'b0;
      else
         cmd_valid <= tog_s2_reg ^ tog_s3_reg;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cmd_kind <= rlt_pkg::RLT_NONE;
         cmd_addr4 <= 1'b0;
         cmd_ok <= 1'b0;
         cmd_mode <= '0;
         cmd_dummy <= '0;
      end
      else if (tog_s2_reg ^ tog_s3_reg)
      begin
         cmd_kind <= evt_cmd_reg;
         cmd_addr4 <= evt_a4_reg;
         cmd_ok <= (evt_cyc_reg.mode != `RLT_UNSUP); // R04 R05
         cmd_mode <= evt_cyc_reg.mode;
         cmd_dummy <= evt_cyc_reg.dummy;
      end
   end

endmodule

// file: verilog/rlt_host.sv
`timescale 1ns/1ps
`include "rlt_consts.svh"

module rlt_fifo
#(
   parameter int WIDTH = 8, // word width
   parameter int DEPTH = 16 // entries, power of two
)
(
   input wire logic rst, // async reset, active high
   input wire logic clk, // system clock
   input wire logic in_valid, // write request
   output logic in_ready, // not full
   input wire logic [WIDTH-1:0] in_data, // write word
   output logic out_valid, // not empty
   input wire logic out_ready, // read accept
   output logic [WIDTH-1:0] out_data // head word
);
   localparam int AW = $clog2(DEPTH);
   logic [AW:0] wr_reg;
   logic [AW:0] rd_reg;
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic push;
   logic pop;

   assign in_ready = !((wr_reg[AW] != rd_reg[AW]) &&
                       (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
   assign out_valid = (wr_reg != rd_reg);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem_reg[rd_reg[AW-1:0]];

   for (genvar gi = 0; gi < DEPTH; gi++)
   begin : g_ent
      always_ff @(posedge clk or posedge rst)
      begin
         if (rst)
            mem_reg[gi] <= '0;
         else if (push && wr_reg[AW-1:0] == AW'(gi))
            mem_reg[gi] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         wr_reg <= '0;
      else if (push)
         wr_reg <= wr_reg + 1'b1;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rd_reg <= '0;
      else if (pop)
         rd_reg <= rd_reg + 1'b1;
   end
endmodule

module rlt_host
#(
   parameter int SCK_HALF = `RLT_SCK_HALF, // clk cycles per sclk half
   parameter int DEPTH = `RLT_FIFO_DEPTH // reply buffer depth
)
(
   input wire logic rst, // async reset, active high
   input wire logic clk, // system clock
   rlt_if.host link, // serial link, host end
   input wire logic [1:0] lat_code, // code the device is set to
   input wire logic high_band, // sclk above 104 MHz
   input wire logic req_valid, // frame request
   output logic req_ready, // idle, request taken
   input wire logic [7:0] req_op, // opcode byte
   input wire logic [7:0] req_addr, // second byte
   input wire logic [7:0] req_len, // reply bytes to read
   output logic req_reject, // pulse: command refused
   output logic rx_valid, // reply byte available
   input wire logic rx_ready, // reply byte taken
   output logic [7:0] rx_data, // reply byte
   output logic [7:0] param_next, // next parameter offset
   output logic busy // frame in progress
);
   rlt_pkg::rlt_hstate_e state_reg;
   logic [7:0] div_reg;
   logic sclk_reg;
   logic cs_n_reg;
   logic mosi_reg;
   logic [15:0] tx_sh_reg;
   logic [11:0] bit_idx_reg;
   logic [11:0] total_reg;
   logic [7:0] rx_sh_reg;
   logic [7:0] rxn_reg;
   logic pend_reg;
   logic [7:0] pend_data_reg;
   logic tbl_reg;
   logic [7:0] base_reg;
   logic miso_s1_reg;
   logic miso_s2_reg;
   logic fifo_in_ready;
   logic stall;
   logic tick;
   logic rise;
   logic accept;
   logic refuse;
   logic start;
   logic last_fall;
   logic byte_done;
   logic [7:0] rx_byte;
   rlt_pkg::rlt_cmd_e req_cmd;

   assign link.sclk = sclk_reg;
   assign link.cs_n = cs_n_reg;
   assign link.mosi = mosi_reg;
   assign req_ready = (state_reg == rlt_pkg::HS_IDLE);
   assign busy = (state_reg != rlt_pkg::HS_IDLE);
   assign accept = req_valid & req_ready;
   assign req_cmd = rlt_pkg::op_cmd(req_op);
   // reads unsupported at the lat_code seen on acceptance never reach the link
   assign refuse = (req_cmd != rlt_pkg::RLT_NONE) &&
      (rlt_pkg::cyc(rlt_pkg::row_of(lat_code, high_band),
                    req_cmd).mode == `RLT_UNSUP); // R04 R05 R14
   assign start = accept & ~refuse;
   // sclk pauses while a finished byte waits for buffer room
   assign stall = pend_reg & ~fifo_in_ready;
   assign tick = (state_reg == rlt_pkg::HS_RUN) & ~stall &
                 (div_reg == 8'(SCK_HALF - 1));
   assign rise = tick & ~sclk_reg;
   assign last_fall = tick & sclk_reg & (bit_idx_reg == total_reg);
   assign rx_byte = {rx_sh_reg[6:0], miso_s2_reg};
   assign byte_done = rise & (bit_idx_reg >= `RLT_HDR_BITS) &
                      (bit_idx_reg[2:0] == 3'h7);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         miso_s1_reg <= 1'b0;
         miso_s2_reg <= 1'b0;
      end
      else
      begin
         miso_s1_reg <= link.miso;
         miso_s2_reg <= miso_s1_reg;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         state_reg <= rlt_pkg::HS_IDLE;
      else
      begin
         case (state_reg)
            rlt_pkg::HS_IDLE:
               if (start) state_reg <= rlt_pkg::HS_RUN;
            rlt_pkg::HS_RUN:
               if (last_fall) state_reg <= rlt_pkg::HS_END;
            rlt_pkg::HS_END:
               if (!pend_reg) state_reg <= rlt_pkg::HS_IDLE;
            default: state_reg <= rlt_pkg::HS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         div_reg <= '0;
      else if (state_reg != rlt_pkg::HS_RUN || tick)
         div_reg <= '0;
      else if (!stall)
         div_reg <= div_reg + 8'h01;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sclk_reg <= 1'b0;
         cs_n_reg <= 1'b1;
      end
      else
      begin
         if (tick)
            sclk_reg <= ~sclk_reg;
         if (start)
            cs_n_reg <= 1'b0;
         else if (last_fall)
            cs_n_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tx_sh_reg <= '0;
         mosi_reg <= 1'b0;
         total_reg <= '0;
         tbl_reg <= 1'b0;
         base_reg <= '0;
      end
      else if (start)
      begin
         tx_sh_reg <= {req_op, req_addr};
         mosi_reg <= req_op[7];
         total_reg <= `RLT_HDR_BITS + {1'b0, req_len, 3'b000};
         tbl_reg <= (req_op == `RLT_OP_TBL);
         base_reg <= req_addr;
      end
      else if (tick & sclk_reg)
      begin
         tx_sh_reg <= {tx_sh_reg[14:0], 1'b0};
         mosi_reg <= tx_sh_reg[14];
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         bit_idx_reg <= '0;
         rx_sh_reg <= '0;
         rxn_reg <= '0;
      end
      else if (start)
      begin
         bit_idx_reg <= '0;
         rxn_reg <= '0;
      end
      else if (rise)
      begin
         bit_idx_reg <= bit_idx_reg + 12'h001;
         if (bit_idx_reg >= `RLT_HDR_BITS)
            rx_sh_reg <= rx_byte;
         if (byte_done)
            rxn_reg <= rxn_reg + 8'h01;
      end
   end

   // a new byte outranks the clear of pend_reg; the old one is still pushed that cycle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pend_reg <= 1'b0;
         pend_data_reg <= '0;
      end
      else if (byte_done)
      begin
         pend_reg <= 1'b1;
         pend_data_reg <= rx_byte;
      end
      else if (fifo_in_ready)
         pend_reg <= 1'b0;
   end

   // length byte is the second reply byte of a parameter read
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         param_next <= '0;
      else if (byte_done && tbl_reg && rxn_reg == 8'h01)
         param_next <= base_reg + 8'h02 + rx_byte; // R10
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         req_reject <= 1'b0;
      else
         req_reject <= accept & refuse; // R14
   end

   rlt_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
      .rst(rst),
      .clk(clk),
      .in_valid(pend_reg),
      .in_ready(fifo_in_ready),
      .in_data(pend_data_reg),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data(rx_data)
   );
endmodule
